// ### design/host_bus_pin_behaviour.sv
// parallel host port pin logic for three bus styles with wait/acknowledge
// assumes style is a static strap and core read data is valid when asked
`timescale 1ns/1ps
module host_bus_pin_behaviour
#(
    parameter int BUSY_CYCLES = host_port_pkg::ACCESS_CYCLES
)
(
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst_n,
    // configuration
    input  wire host_port_pkg::bus_style_e         busStyle,
    // host pins
    input  wire host_port_pkg::host_pins_s         pins,
    output logic [host_port_pkg::DATA_W-1:0]       dataOut,
    output logic                                   dataOe,
    output logic                                   waitOut,
    output logic                                   waitOe,
    // core side
    input  wire logic [host_port_pkg::DATA_W-1:0]  coreRdData,
    output host_port_pkg::access_s                 access
);
    import host_port_pkg::*;

    typedef struct packed {
        logic              prevWr;
        logic              prevRd;
        logic              prevAs;
        logic [ADDR_W-1:0] latAddr;
        phase_e            phase;
        logic [3:0]        busy;
        logic              pendWrite;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
        logic              waitOut;
        logic              waitOe;
        access_s           access;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic ackLevel(input bus_style_e s, input logic done);
        // generic: low = wait, high = done; strobe style: high = wait, low = done
        ackLevel = (s == STYLE_STROBE) ? ~done : done;
    endfunction

    logic selected;
    logic wrRise;
    logic enRise;
    logic ldsFall;
    logic rdFall;
    logic start;
    logic startWrite;
    logic asFall;
    logic [ADDR_W-1:0] cycAddr;

    always_comb
    begin
        selected = ~pins.chipSel_n; // RL3
        wrRise   = pins.wrPin & ~st.prevWr;
        rdFall   = ~pins.rdPin & st.prevRd;
        enRise   = pins.rdPin & ~st.prevRd; // RL14
        ldsFall  = ~pins.rdPin & st.prevRd; // RL15
        asFall   = ~pins.addr_strobe_n & st.prevAs;
        // both strobes may fall on one edge: forward the pin address then
        cycAddr  = (busStyle != STYLE_STROBE) ? pins.addr
                 : (asFall ? pins.addr : st.latAddr); // RL11
        start      = 1'b0;
        startWrite = 1'b0;
        case (busStyle)
            STYLE_GENERIC:
            begin
                // RL10: address strobe ignored, host ties it high
                start      = selected & (rdFall | (~pins.wrPin & st.prevWr));
                startWrite = ~pins.wrPin;
            end
            STYLE_ENABLE:
            begin
                start      = selected & enRise;
                startWrite = ~pins.wrPin; // RL1
            end
            STYLE_STROBE:
            begin
                start      = selected & ~pins.addr_strobe_n & ldsFall; // RL11
                startWrite = ~pins.wrPin; // RL2
            end
            default:
            begin
                start      = 1'b0;
                startWrite = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_st              = st;
        next_st.prevWr       = pins.wrPin;
        next_st.prevRd       = pins.rdPin;
        next_st.prevAs       = pins.addr_strobe_n;
        next_st.access.valid = 1'b0;
        if (busStyle == STYLE_STROBE)
        begin
            if (asFall)
                next_st.latAddr = pins.addr; // RL11
        end
        else
            next_st.latAddr = pins.addr;
        // generic write: data taken at write strobe rising edge
        if (busStyle == STYLE_GENERIC && selected && wrRise)
        begin
            next_st.access.valid = 1'b1; // RL12
            next_st.access.write = 1'b1;
            next_st.access.addr  = pins.addr;
            next_st.access.data  = pins.dataIn;
        end
        else if (busStyle != STYLE_GENERIC && start && startWrite)
        begin
            next_st.access.valid = 1'b1; // RL14 RL15
            next_st.access.write = 1'b1;
            next_st.access.addr  = cycAddr;
            next_st.access.data  = pins.dataIn;
        end
        else if (start && !startWrite)
        begin
            next_st.access.valid = 1'b1;
            next_st.access.write = 1'b0;
            next_st.access.addr  = cycAddr;
            next_st.access.data  = '0;
        end
        // read drivers
        case (busStyle)
            STYLE_GENERIC: next_st.dataOe = selected & ~pins.rdPin; // RL13
            STYLE_ENABLE:  next_st.dataOe = selected & pins.rdPin & pins.wrPin; // RL1
            STYLE_STROBE:  next_st.dataOe = selected & ~pins.rdPin & pins.wrPin; // RL2
            default:       next_st.dataOe = 1'b0;
        endcase
        next_st.dataOut = coreRdData;
        // wait / acknowledge handshake
        case (st.phase)
            PH_IDLE:
            begin
                next_st.waitOe = 1'b0;
                if (start && busStyle != STYLE_ENABLE) // RL9
                begin
                    next_st.phase   = PH_BUSY;
                    next_st.busy    = 4'(BUSY_CYCLES - 1);
                    next_st.waitOe  = 1'b1; // RL4 RL7
                    next_st.waitOut = ackLevel(busStyle, 1'b0);
                end
            end
            PH_BUSY:
            begin
                if (st.busy == 4'h0)
                begin
                    next_st.phase   = PH_DONE;
                    next_st.waitOut = ackLevel(busStyle, 1'b1); // RL6 RL8
                end
                else
                    next_st.busy = st.busy - 4'h1;
            end
            PH_DONE:
            begin
                // hold completion until the host ends its strobe
                // strobe style: direction may still read low as the strobe rises
                if (pins.rdPin && (pins.wrPin || busStyle == STYLE_STROBE))
                begin
                    next_st.phase  = PH_IDLE;
                    next_st.waitOe = 1'b0; // RL5
                end
                else if (busStyle == STYLE_GENERIC && !pins.wrPin)
                    next_st.waitOe = 1'b1;
            end
            default: next_st.phase = PH_IDLE;
        endcase
        if (!selected)
        begin
            next_st.phase  = PH_IDLE; // RL16
            next_st.waitOe = 1'b0;
            next_st.dataOe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st         <= '0;
            st.prevWr  <= 1'b1;
            st.prevRd  <= 1'b1;
            st.prevAs  <= 1'b1;
            st.busy    <= BUSY_RESET;
            st.phase   <= PH_IDLE;
            st.waitOut <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign dataOut = st.dataOut;
    assign dataOe  = st.dataOe;
    assign waitOut = st.waitOut;
    assign waitOe  = st.waitOe;
    assign access  = st.access;

    sequence waitBusy_s;
        st.phase == PH_BUSY && waitOe;
    endsequence

    sequence genBusy_s;
        st.phase == PH_BUSY && waitOe && busStyle == STYLE_GENERIC;
    endsequence

    sequence ackBusy_s;
        st.phase == PH_BUSY && waitOe && busStyle == STYLE_STROBE;
    endsequence

    deselFloat_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
        pins.chipSel_n |=> !waitOe && !dataOe)
        else $error("outputs driven while deselected");
    enableNoWait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL9
        busStyle == STYLE_ENABLE && $past(busStyle) == STYLE_ENABLE && st.phase == PH_IDLE
        |=> !waitOe)
        else $error("wait driven in enable style");
    genWaitLow_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
        genBusy_s |-> !waitOut)
        else $error("generic wait not low while busy");
    ackHigh_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
        ackBusy_s |-> waitOut)
        else $error("acknowledge not high while busy");
    busyEnds_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
        waitBusy_s |-> ##[1:16] (st.phase != PH_BUSY))
        else $error("transfer never completes");
    readDrive_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
        busStyle == STYLE_GENERIC && dataOe |-> $past(!pins.rdPin && !pins.chipSel_n))
        else $error("drivers on without read strobe");
    wrCapture_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
        busStyle == STYLE_GENERIC && !pins.chipSel_n && pins.wrPin && !st.prevWr
        |=> access.valid && access.write && access.data == $past(pins.dataIn))
        else $error("write data not taken at strobe rise");
    strobeXfer_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
        busStyle == STYLE_STROBE && !pins.chipSel_n && !pins.addr_strobe_n
        && !pins.rdPin && st.prevRd |=> access.valid && access.write == $past(!pins.wrPin))
        else $error("strobe style access missed");
    enXfer_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL14
        busStyle == STYLE_ENABLE && !pins.chipSel_n && pins.rdPin && !st.prevRd
        |=> access.valid && access.write == $past(!pins.wrPin))
        else $error("enable style access missed");
    releaseAfter_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
        st.phase == PH_DONE && pins.rdPin && !pins.chipSel_n
        && (pins.wrPin || busStyle == STYLE_STROBE) |=> !waitOe)
        else $error("wait not released after completion");

endmodule // host_bus_pin_behaviour

// ### design/host_port_pkg.sv
// constants and carrier types for the parallel host port front end
// assumes one 250 MHz clock and pins already synchronous to it
// Summary of operation
// RL1 - enable style: direction high reads, low writes
// RL2 - strobe style: direction high reads, low writes
// RL3 - cycles only while chip select low
// RL4 - generic style: wait low during transfer
// RL5 - wait released to high impedance afterwards
// RL6 - indirect generic: wait serves as handshake
// RL7 - strobe style: acknowledge active high, released; code drives it high while busy and low when done
// RL8 - indirect strobe style: acknowledge as handshake
// RL9 - enable style: host ignores wait output
// RL10 - generic style: address strobe held high
// RL11 - strobe style: address strobe qualifies address
// RL12 - generic: data captured on write rising edge
// RL13 - generic: drivers on only while read low
// RL14 - enable style: transfer on enable rising
// RL15 - strobe style: transfer when lower strobe falls
// RL16 - wait output floats when deselected
package host_port_pkg;

    typedef enum logic [1:0] {STYLE_GENERIC, STYLE_ENABLE, STYLE_STROBE} bus_style_e;
    typedef enum logic [1:0] {PH_IDLE, PH_BUSY, PH_DONE} phase_e;

    localparam int DATA_W        = 8;
    localparam int ADDR_W        = 1;
    localparam int ACCESS_CYCLES = 4;
    localparam logic [3:0] BUSY_RESET = 4'h0;

    // host-side pins, sampled each clock
    typedef struct packed {
        logic              chipSel_n;
        logic              rdPin;
        logic              wrPin;
        logic              addr_strobe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataIn;
    } host_pins_s;

    // one completed access toward the core
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } access_s;

endpackage

// ### bench/host_cpu_model.sv
// behavioural host processor driving the parallel port pins
// assumes pins change at falling edges; wait pin has a board pull-up
`timescale 1ns/1ps
module host_cpu_model
    import host_port_pkg::*;
(
    // clock
    input  wire logic              ref_clk,
    // bus pins
    output host_pins_s             pins,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic              dataOe,
    input  wire logic              waitOut,
    input  wire logic              waitOe
);
    logic waitLine;

    // released pin floats up to the pull-up level
    assign waitLine = waitOe ? waitOut : 1'b1;

    initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, '0, 8'h00};

    task automatic run(input bus_style_e st, input logic sel, input logic wr,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output int n, output logic sawWait, output logic sawBusy,
                       output logic [DATA_W-1:0] rdData, output logic tmo);
        logic doneLvl;
        n = 0;
        sawWait = 1'b0;
        sawBusy = 1'b0;
        rdData = 'x;
        doneLvl = (st == STYLE_GENERIC);
        @(negedge ref_clk);
        pins.chipSel_n = ~sel;
        pins.addr = a;
        pins.dataIn = wr ? d : ~d;
        pins.addr_strobe_n = (st != STYLE_STROBE);
        pins.wrPin = ~wr;
        pins.rdPin = (st == STYLE_GENERIC) ? wr : 1'b0;
        if (st == STYLE_ENABLE)
            @(negedge ref_clk) pins.rdPin = 1'b1;
        // enable style and deselected cycles end after 4 clocks, not on the wait pin
        do
        begin
            @(negedge ref_clk);
            n++;
            sawWait |= waitOe;
            if (waitOe && waitLine != doneLvl)
                sawBusy = 1'b1;
            if (dataOe)
                rdData = dataOut;
        end
        while ((st == STYLE_ENABLE || !sel) ? n < 4
               : !(waitOe && waitLine == doneLvl) && n < 40);
        tmo = (n >= 40);
        // end strobes while still selected so a write strobe rise lands
        pins.rdPin = (st != STYLE_ENABLE);
        pins.wrPin = 1'b1;
        pins.addr_strobe_n = 1'b1;
        @(negedge ref_clk);
        pins.chipSel_n = 1'b1;
        pins.dataIn = ~pins.dataIn;
        repeat (2) @(negedge ref_clk);
    endtask
endmodule // host_cpu_model

// ### bench/test_host_bus_pin_behaviour.sv
// self-checking bench for the host port pin logic
// assumes the host model above owns all pin stimulus
`timescale 1ns/1ps
module test_host_bus_pin_behaviour;
    import host_port_pkg::*;
    localparam int BUSY = 3;
    logic              ref_clk, rst_n, dataOe, waitOut, waitOe, sawWait, sawBusy, tmo;
    bus_style_e        busStyle;
    host_pins_s        pins;
    logic [DATA_W-1:0] dataOut, coreRdData, rdData;
    access_s           access, lastAcc;
    int                miscompares = 0, samples_checked = 0, accCount = 0, n, c0;

    host_bus_pin_behaviour #(.BUSY_CYCLES(BUSY)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .busStyle(busStyle), .pins(pins), .dataOut(dataOut), .dataOe(dataOe),
        .waitOut(waitOut), .waitOe(waitOe), .coreRdData(coreRdData), .access(access));
    host_cpu_model u_host (.ref_clk(ref_clk), .pins(pins), .dataOut(dataOut),
        .dataOe(dataOe), .waitOut(waitOut), .waitOe(waitOe));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (access.valid === 1'b1)
        begin
            lastAcc <= access;
            accCount <= accCount + 1;
        end

    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic chkByte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        chkBit(got === exp, 1'b1, "read data");
    endtask

    task automatic chkAcc(input logic wr, input logic a, input logic [DATA_W-1:0] d);
        chkBit(accCount == c0 + 1, 1'b1, "access count");
        chkBit(lastAcc.write, wr, "access direction");
        chkBit(lastAcc.addr[0], a, "access address");
        if (wr)
            chkBit(lastAcc.data === d, 1'b1, "write data");
    endtask

    task automatic go(input bus_style_e st, input logic sel, input logic wr, input logic a,
                      input logic [DATA_W-1:0] d);
        c0 = accCount;
        busStyle = st;
        u_host.run(st, sel, wr, a, d, n, sawWait, sawBusy, rdData, tmo);
        if (tmo)
        begin
            miscompares++;
            $display("mismatch at %0t: wait never completed", $time);
            wrap_up();
        end
    endtask

    task automatic genericCycles();
        go(STYLE_GENERIC, 1'b1, 1'b1, 1'b1, 8'ha5);
        chkBit(sawBusy, 1'b1, "no wait state");
        chkBit(n == BUSY + 1, 1'b1, "completion time");
        chkBit(waitOe, 1'b0, "wait not released");
        chkAcc(1'b1, 1'b1, 8'ha5);
        coreRdData = 8'h3c;
        go(STYLE_GENERIC, 1'b1, 1'b0, 1'b0, 8'h00);
        chkBit(sawBusy, 1'b1, "no wait on read");
        chkByte(rdData, 8'h3c);
        chkBit(dataOe, 1'b0, "drivers left on");
        chkAcc(1'b0, 1'b0, 8'h00);
    endtask

    task automatic strobeCycles();
        go(STYLE_STROBE, 1'b1, 1'b1, 1'b1, 8'h96);
        chkBit(sawBusy, 1'b1, "ack not high in transfer");
        chkBit(n == BUSY + 1, 1'b1, "ack time");
        chkBit(waitOe, 1'b0, "ack not released");
        chkAcc(1'b1, 1'b1, 8'h96);
        coreRdData = 8'hc3;
        go(STYLE_STROBE, 1'b1, 1'b0, 1'b0, 8'h00);
        chkBit(sawBusy, 1'b1, "no ack wait on read");
        chkByte(rdData, 8'hc3);
        chkBit(dataOe, 1'b0, "drivers left on");
        chkAcc(1'b0, 1'b0, 8'h00);
    endtask

    task automatic deselected();
        go(STYLE_GENERIC, 1'b0, 1'b1, 1'b1, 8'h11);
        chkBit(sawWait, 1'b0, "wait driven unselected");
        chkBit(accCount == c0, 1'b1, "access unselected");
        go(STYLE_STROBE, 1'b0, 1'b0, 1'b0, 8'h00);
        chkBit(sawWait, 1'b0, "ack driven unselected");
        chkBit(accCount == c0, 1'b1, "access unselected");
    endtask

    task automatic enableCycles();
        go(STYLE_ENABLE, 1'b1, 1'b1, 1'b0, 8'h5e);
        chkBit(sawWait, 1'b0, "wait driven in enable style");
        chkAcc(1'b1, 1'b0, 8'h5e);
        coreRdData = 8'he7;
        go(STYLE_ENABLE, 1'b1, 1'b0, 1'b1, 8'h00);
        chkByte(rdData, 8'he7);
        chkAcc(1'b0, 1'b1, 8'h00);
    endtask

    initial
    begin
        rst_n = 1'b0;
        busStyle = STYLE_GENERIC;
        coreRdData = 8'h00;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        genericCycles();
        strobeCycles();
        deselected();
        enableCycles();
        wrap_up();
    end
endmodule // test_host_bus_pin_behaviour
